// *** design/cam_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cam_map.svh"

// Summary of operation
// - Direct address comes from instruction byte
// - Indirect address is selected pointer value
// - Access at pointer, then step pointer
// - Immediate byte fetched after the opcode
// - Short load: nibble low, upper cleared
// - Table read via upper PC and accumulator
// - PC is fifteen bits, two bytes
// - Relative jump spans -31 to +32
// - Block jump replaces low twelve bits
// - Long jump loads all fifteen bits
// - Table jump loads lower PC byte
// - Vector jump loads two-byte vector
// - Failed test turns next into no-op
module cam_core
    import cam_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Decoded command
    input  wire logic                    cmd_valid,
    input  wire cam_cmd_t                cmd,
    output logic                         cmd_ready,
    // Accumulator from the datapath
    input  wire logic [7:0]              acc,
    // Program memory, data one cycle after read
    output logic [`CAM_PC_W-1:0]         prog_addr,
    output logic                         prog_rd,
    input  wire logic [7:0]              prog_data,
    // Data memory operand address
    output logic [`CAM_DADDR_W-1:0]      dmem_addr,
    output logic                         dmem_req,
    // Results
    output logic [7:0]                   operand,
    output logic                         operand_valid,
    output logic [7:0]                   acc_data,
    output logic                         acc_load,
    output logic [`CAM_PC_W-1:0]         pc,
    output logic [7:0]                   ptr_b,
    output logic [7:0]                   ptr_x,
    output logic                         done
);

    cam_state_t state;
    cam_state_t next_state;
    cam_op_t    op_q;
    logic       skip_pending;
    logic [7:0] vec_hi;
    logic       accept;
    logic       work;
    logic       skip_run;
    logic       ind_b;
    logic       ind_x;

    // Command handshake and skip decision
    assign accept   = cmd_valid && cmd_ready;
    assign skip_run = accept && skip_pending;
    assign work     = accept && !skip_pending;
    assign ind_b    = work && (cmd.op == CAM_OP_INDIRECT) && !cmd.ptr_sel;
    assign ind_x    = work && (cmd.op == CAM_OP_INDIRECT) && cmd.ptr_sel;

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            CAM_S_IDLE:
                if (work && (cmd.op == CAM_OP_IMMEDIATE || cmd.op == CAM_OP_TABLE_READ ||
                             cmd.op == CAM_OP_TABLE_JUMP || cmd.op == CAM_OP_VECTOR_JUMP))
                    next_state = CAM_S_RD;
            CAM_S_RD, CAM_S_RD2:
                next_state = (state == CAM_S_RD) ? CAM_S_CAP : CAM_S_CAP2;
            CAM_S_CAP:
                next_state = (op_q == CAM_OP_VECTOR_JUMP) ? CAM_S_RD2 : CAM_S_IDLE;
            CAM_S_CAP2:
                next_state = CAM_S_IDLE;
        endcase
    end

    // State, ready and latched operation
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= CAM_S_IDLE;
            cmd_ready <= 1'b0;
            op_q      <= CAM_OP_STEP;
        end
        else
        begin
            state     <= next_state;
            cmd_ready <= (next_state == CAM_S_IDLE);
            if (work)
                op_q <= cmd.op;
        end
    end

    // Skip flag set by a failed test, spent on the next command
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            skip_pending <= 1'b0;
        else if (accept)
            skip_pending <= work && cmd.test_failed;
    end

    // Program counter
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pc <= `CAM_PC_RST;
        else if (skip_run)
            pc <= pc + `CAM_PC_W'(cmd.len);
        else if (work)
        begin
            unique case (cmd.op)
                CAM_OP_REL_JUMP:
                    pc <= pc + `CAM_PC_W'(cmd.arg[`CAM_DISP_W-1:0]) - `CAM_REL_BIAS;
                CAM_OP_BLOCK_JUMP:
                    pc <= {pc[14:12], cmd.arg[`CAM_BLOCK_LSB_W-1:0]};
                CAM_OP_LONG_JUMP:
                    pc <= cmd.arg;
                CAM_OP_TABLE_READ, CAM_OP_TABLE_JUMP, CAM_OP_VECTOR_JUMP:
                    pc <= pc;
                default:
                    pc <= pc + `CAM_PC_W'(cmd.len);
            endcase
        end
        else if (state == CAM_S_CAP && op_q == CAM_OP_TABLE_READ)
            pc <= pc + `CAM_PC_W'(1);
        else if (state == CAM_S_CAP && op_q == CAM_OP_TABLE_JUMP)
            pc[7:0] <= prog_data;
        else if (state == CAM_S_CAP2)
            pc <= {vec_hi[6:0], prog_data};
    end

    // Program memory address and read strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_addr <= `CAM_PC_RST;
            prog_rd   <= 1'b0;
        end
        else
        begin
            prog_rd <= (next_state == CAM_S_RD) || (next_state == CAM_S_RD2);
            if (work && cmd.op == CAM_OP_IMMEDIATE)
                prog_addr <= pc + `CAM_PC_W'(1);
            else if (work && (cmd.op == CAM_OP_TABLE_READ || cmd.op == CAM_OP_TABLE_JUMP))
                prog_addr <= {pc[14:8], acc};
            else if (work && cmd.op == CAM_OP_VECTOR_JUMP)
                prog_addr <= cmd.arg;
            else if (state == CAM_S_CAP && op_q == CAM_OP_VECTOR_JUMP)
                prog_addr <= prog_addr + `CAM_PC_W'(1);
        end
    end

    // Data memory operand address, taken before any pointer step
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dmem_addr <= 8'h00;
            dmem_req  <= 1'b0;
        end
        else
        begin
            dmem_req <= work && (cmd.op == CAM_OP_DIRECT || cmd.op == CAM_OP_INDIRECT);
            if (work && cmd.op == CAM_OP_DIRECT)
                dmem_addr <= cmd.arg[7:0];
            else if (work && cmd.op == CAM_OP_INDIRECT)
                dmem_addr <= cmd.ptr_sel ? ptr_x : ptr_b;
        end
    end

    // Captured program bytes and completion pulse
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operand       <= 8'h00;
            operand_valid <= 1'b0;
            acc_data      <= 8'h00;
            acc_load      <= 1'b0;
            vec_hi        <= 8'h00;
            done          <= 1'b0;
        end
        else
        begin
            operand_valid <= (state == CAM_S_CAP) && (op_q == CAM_OP_IMMEDIATE);
            acc_load      <= (state == CAM_S_CAP) && (op_q == CAM_OP_TABLE_READ);
            done          <= skip_run || (state == CAM_S_CAP2) || (work && (next_state == CAM_S_IDLE)) ||
                             ((state == CAM_S_CAP) && (op_q != CAM_OP_VECTOR_JUMP));
            if (state == CAM_S_CAP && op_q == CAM_OP_IMMEDIATE)
                operand <= prog_data;
            if (state == CAM_S_CAP && op_q == CAM_OP_TABLE_READ)
                acc_data <= prog_data;
            if (state == CAM_S_CAP && op_q == CAM_OP_VECTOR_JUMP)
                vec_hi <= prog_data;
        end
    end

    // First pointer: short load and post-modify
    cam_ptr_reg u_ptr_b
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (work && cmd.op == CAM_OP_LOAD_PTR_SHORT),
        .load_val ({`CAM_NIB_CLR, cmd.arg[`CAM_NIB_W-1:0]}),
        .inc      (ind_b && cmd.post == CAM_POST_INC),
        .dec      (ind_b && cmd.post == CAM_POST_DEC),
        .value    (ptr_b)
    );

    // Second pointer: post-modify only
    cam_ptr_reg u_ptr_x
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (1'b0),
        .load_val (8'h00),
        .inc      (ind_x && cmd.post == CAM_POST_INC),
        .dec      (ind_x && cmd.post == CAM_POST_DEC),
        .value    (ptr_x)
    );

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_direct;
        work && cmd.op == CAM_OP_DIRECT |=> dmem_req && dmem_addr == $past(cmd.arg[7:0]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");
    property p_indirect;
        ind_b |=> dmem_req && dmem_addr == $past(ptr_b);
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");
    property p_post_inc;
        ind_x && cmd.post == CAM_POST_INC |=> ptr_x == $past(ptr_x) + 8'h01 && dmem_addr == $past(ptr_x);
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post increment wrong");
    property p_immediate;
        work && cmd.op == CAM_OP_IMMEDIATE |=> prog_rd && prog_addr == $past(pc) + 15'h0001 ##2 operand_valid;
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate fetch wrong");
    property p_short_load;
        work && cmd.op == CAM_OP_LOAD_PTR_SHORT |=> ptr_b == {4'h0, $past(cmd.arg[3:0])};
    endproperty
    a_short_load: assert property (p_short_load) else $error("short pointer load wrong");
    property p_table_read;
        work && cmd.op == CAM_OP_TABLE_READ |=> prog_addr == {$past(pc[14:8]), $past(acc)} ##2
            acc_load && pc == $past(pc, 3) + 15'h0001;
    endproperty
    a_table_read: assert property (p_table_read) else $error("table read wrong");
    property p_rel_jump;
        work && cmd.op == CAM_OP_REL_JUMP |=> pc == $past(pc) + 15'($past(cmd.arg[5:0])) - 15'h001f;
    endproperty
    a_rel_jump: assert property (p_rel_jump) else $error("relative jump wrong");
    property p_block_jump;
        work && cmd.op == CAM_OP_BLOCK_JUMP |=> pc == {$past(pc[14:12]), $past(cmd.arg[11:0])};
    endproperty
    a_block_jump: assert property (p_block_jump) else $error("block jump wrong");
    property p_long_jump;
        work && cmd.op == CAM_OP_LONG_JUMP |=> pc == $past(cmd.arg);
    endproperty
    a_long_jump: assert property (p_long_jump) else $error("long jump wrong");
    property p_table_jump;
        state == CAM_S_CAP && op_q == CAM_OP_TABLE_JUMP |=>
            pc == {$past(pc[14:8]), $past(prog_data)} && done;
    endproperty
    a_table_jump: assert property (p_table_jump) else $error("table jump wrong");
    property p_vector;
        work && cmd.op == CAM_OP_VECTOR_JUMP |=> prog_rd ##2 prog_rd && prog_addr == $past(prog_addr, 2) + 15'h0001
            ##2 done;
    endproperty
    a_vector: assert property (p_vector) else $error("vector jump wrong");
    property p_skip;
        skip_run |=> !dmem_req && !prog_rd && done && pc == $past(pc) + 15'($past(cmd.len));
    endproperty
    a_skip: assert property (p_skip) else $error("skipped command had effect");

    // Main scenario covers
    c_vector:   cover property (state == CAM_S_CAP2 ##1 done);
    c_skip:     cover property (skip_run);
    c_table:    cover property (acc_load);
    c_post_dec: cover property (ind_b && cmd.post == CAM_POST_DEC);

endmodule : cam_core
`default_nettype wire

// *** shared/cam_map.svh ***
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH

// Widths
`define CAM_PC_W        15
`define CAM_DADDR_W     8
`define CAM_ARG_W       15

// Field positions inside the instruction argument
`define CAM_BLOCK_LSB_W 12
`define CAM_DISP_W      6
`define CAM_NIB_W       4

// Relative jump: field holds distance plus this bias (range -31..+32)
`define CAM_REL_BIAS    15'h001f

// Upper nibble forced by the short pointer load
`define CAM_NIB_CLR     4'h0

// Reset values
`define CAM_PC_RST      15'h0000
`define CAM_PTR_RST     8'h00

`endif

// *** shared/cam_pkg.sv ***
package cam_pkg;

    // Addressing operation requested by the decoder
    typedef enum logic [3:0] {
        CAM_OP_STEP,
        CAM_OP_DIRECT,
        CAM_OP_INDIRECT,
        CAM_OP_IMMEDIATE,
        CAM_OP_LOAD_PTR_SHORT,
        CAM_OP_TABLE_READ,
        CAM_OP_REL_JUMP,
        CAM_OP_BLOCK_JUMP,
        CAM_OP_LONG_JUMP,
        CAM_OP_TABLE_JUMP,
        CAM_OP_VECTOR_JUMP
    } cam_op_t;

    // Pointer post-modification
    typedef enum logic [1:0] {
        CAM_POST_NONE,
        CAM_POST_INC,
        CAM_POST_DEC
    } cam_post_t;

    // Sequencer states
    typedef enum logic [2:0] {
        CAM_S_IDLE,
        CAM_S_RD,
        CAM_S_CAP,
        CAM_S_RD2,
        CAM_S_CAP2
    } cam_state_t;

    // One decoded instruction
    typedef struct packed {
        cam_op_t     op;
        logic [1:0]  len;
        logic        test_failed;
        logic        ptr_sel;
        cam_post_t   post;
        logic [14:0] arg;
    } cam_cmd_t;

endpackage : cam_pkg

// *** design/cam_ptr_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cam_map.svh"

module cam_ptr_reg
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Control
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic       inc,
    input  wire logic       dec,
    // Pointer value
    output logic      [7:0] value
);

    // Pointer register, load wins over modify
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            value <= `CAM_PTR_RST;
        else if (load)
            value <= load_val;
        else if (inc)
            value <= value + 8'h01;
        else if (dec)
            value <= value - 8'h01;
    end

endmodule : cam_ptr_reg
`default_nettype wire

// *** test/cam_prog_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cam_prog_mem_model
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Program memory port
    input  wire logic [14:0] prog_addr,
    input  wire logic        prog_rd,
    output logic      [7:0]  prog_data
);
    // Byte one cycle after the strobe, inverted on each idle cycle so stale data read one cycle late is wrong
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prog_data <= 8'h00;
        else if (prog_rd)
            prog_data <= prog_addr[7:0] ^ {1'b0, prog_addr[14:8]} ^ 8'h5a;
        else
            prog_data <= ~prog_data;
    end
endmodule : cam_prog_mem_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb
    import cam_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    cam_cmd_t cmd = '0;
    logic [7:0] acc = 8'h00;
    logic cmd_ready, prog_rd, dmem_req, operand_valid, acc_load, done;
    logic [14:0] prog_addr, pc, exp_pc, rd_first, rd_last;
    logic [7:0] prog_data, dmem_addr, operand, acc_data, ptr_b, ptr_x;
    logic saw_dm, saw_op, saw_acc;
    int n_fail = 0;
    int num_checks = 0;
    int lat;

    // Clock at 4 ns
    always #2 clk_sys = ~clk_sys;

    cam_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .acc(acc), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data), .dmem_addr(dmem_addr),
        .dmem_req(dmem_req), .operand(operand), .operand_valid(operand_valid), .acc_data(acc_data),
        .acc_load(acc_load), .pc(pc), .ptr_b(ptr_b), .ptr_x(ptr_x), .done(done));

    cam_prog_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_data(prog_data));

    // Expected program memory content
    function automatic logic [7:0] pm(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
    endfunction : pm

    function automatic cam_cmd_t mk(input cam_op_t op, input logic [1:0] len, input logic tf,
                                    input logic sel, input cam_post_t post, input logic [14:0] arg);
        return '{op, len, tf, sel, post, arg};
    endfunction : mk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Offer one command, wait for its completion and record what came out
    task automatic run(input cam_cmd_t c, input logic [7:0] a, input int el, input logic chk_pc);
        int k;
        k = 0;
        @(posedge clk_sys);
        cmd <= c;
        acc <= a;
        cmd_valid <= 1'b1;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && k < 20)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 20)
        begin
            n_fail++;
            finish_test();
        end
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        saw_dm = 1'b0;
        saw_op = 1'b0;
        saw_acc = 1'b0;
        lat = 0;
        rd_first = 15'h7fff;
        for (k = 1; k <= 8 && lat == 0; k++)
        begin
            @(negedge clk_sys);
            if (prog_rd === 1'b1 && rd_first === 15'h7fff)
                rd_first = prog_addr;
            if (prog_rd === 1'b1)
                rd_last = prog_addr;
            if (dmem_req === 1'b1)
                saw_dm = 1'b1;
            if (operand_valid === 1'b1)
                saw_op = 1'b1;
            if (acc_load === 1'b1)
                saw_acc = 1'b1;
            if (done === 1'b1)
                lat = k;
        end
        check(15'(lat), 15'(el));
        if (chk_pc)
            check(pc, exp_pc);
    endtask : run

    task automatic t_operand();
        exp_pc = 15'h0002;
        run(mk(CAM_OP_DIRECT, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h00a5), 8'h00, 1, 1'b1);
        check(15'(dmem_addr), 15'h00a5);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_INDIRECT, 2'd1, 1'b0, 1'b0, CAM_POST_DEC, 15'h0000), 8'h00, 1, 1'b1);
        check(15'(dmem_addr), 15'h0000);
        check(15'(ptr_b), 15'h00ff);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_INDIRECT, 2'd1, 1'b0, 1'b1, CAM_POST_INC, 15'h0000), 8'h00, 1, 1'b1);
        check(15'(ptr_x), 15'h0001);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_INDIRECT, 2'd1, 1'b0, 1'b1, CAM_POST_NONE, 15'h0000), 8'h00, 1, 1'b1);
        check(15'(dmem_addr), 15'h0001);
        check(15'({saw_dm, ptr_b}), 15'h01ff);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_LOAD_PTR_SHORT, 2'd1, 1'b0, 1'b0, CAM_POST_NONE, 15'h7ff7), 8'h00, 1, 1'b1);
        check(15'(ptr_b), 15'h0007);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_INDIRECT, 2'd1, 1'b0, 1'b0, CAM_POST_INC, 15'h0000), 8'h00, 1, 1'b1);
        check(15'({dmem_addr, ptr_b}), 15'h0708);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_INDIRECT, 2'd1, 1'b0, 1'b1, CAM_POST_DEC, 15'h0000), 8'h00, 1, 1'b1);
        check(15'({dmem_addr, ptr_x}), 15'h0100);
        $display("test operand done");
    endtask : t_operand

    task automatic t_jumps();
        // Distances kept clear of +1
        int dists [3] = '{-31, 10, 32};
        exp_pc = 15'h3625;
        run(mk(CAM_OP_LONG_JUMP, 2'd3, 1'b0, 1'b0, CAM_POST_NONE, 15'h3625), 8'h00, 1, 1'b1);
        exp_pc = 15'h3125;
        run(mk(CAM_OP_BLOCK_JUMP, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h0125), 8'h00, 1, 1'b1);
        foreach (dists[i])
        begin
            exp_pc = exp_pc + 15'(dists[i]);
            run(mk(CAM_OP_REL_JUMP, 2'd1, 1'b0, 1'b0, CAM_POST_NONE, 15'(dists[i] + 31)), 8'h00, 1, 1'b1);
        end
        exp_pc = 15'({pm(15'h7e00) & 8'h7f, pm(15'h7e01)});
        run(mk(CAM_OP_VECTOR_JUMP, 2'd1, 1'b0, 1'b0, CAM_POST_NONE, 15'h7e00), 8'h00, 5, 1'b1);
        check(rd_first, 15'h7e00);
        check(rd_last, 15'h7e01);
        $display("test jumps done");
    endtask : t_jumps

    task automatic t_program();
        logic [14:0] p;
        p = exp_pc;
        exp_pc = p + 15'd2;
        run(mk(CAM_OP_IMMEDIATE, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h0000), 8'h00, 3, 1'b1);
        check(rd_first, p + 15'd1);
        check(15'({saw_op, operand}), {7'h01, pm(p + 15'd1)});
        p = exp_pc;
        exp_pc = p + 15'd1;
        run(mk(CAM_OP_TABLE_READ, 2'd1, 1'b0, 1'b0, CAM_POST_NONE, 15'h0000), 8'h1f, 3, 1'b1);
        check(rd_first, {p[14:8], 8'h1f});
        check(15'({saw_acc, acc_data}), {7'h01, pm({p[14:8], 8'h1f})});
        p = exp_pc;
        exp_pc = {p[14:8], pm({p[14:8], 8'h26})};
        run(mk(CAM_OP_TABLE_JUMP, 2'd1, 1'b0, 1'b0, CAM_POST_NONE, 15'h0000), 8'h26, 3, 1'b1);
        check(rd_first, {p[14:8], 8'h26});
        $display("test program done");
    endtask : t_program

    task automatic t_skip();
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_STEP, 2'd1, 1'b1, 1'b0, CAM_POST_NONE, 15'h0000), 8'h00, 1, 1'b1);
        exp_pc = exp_pc + 15'd2;
        run(mk(CAM_OP_DIRECT, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h0033), 8'h00, 1, 1'b1);
        check(15'(saw_dm), 15'h0000);
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_STEP, 2'd1, 1'b1, 1'b0, CAM_POST_NONE, 15'h0000), 8'h00, 1, 1'b1);
        exp_pc = exp_pc + 15'd2;
        run(mk(CAM_OP_IMMEDIATE, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h0000), 8'h00, 1, 1'b1);
        check(rd_first, 15'h7fff);
        check(15'(saw_op), 15'h0000);
        exp_pc = exp_pc + 15'd2;
        run(mk(CAM_OP_DIRECT, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h0044), 8'h00, 1, 1'b1);
        check(15'({saw_dm, dmem_addr}), 15'h0144);
        $display("test skip done");
    endtask : t_skip

    // Reset in mid-run with a skip pending, then resume
    task automatic t_reset();
        exp_pc = exp_pc + 15'd1;
        run(mk(CAM_OP_STEP, 2'd1, 1'b1, 1'b0, CAM_POST_NONE, 15'h0000), 8'h00, 1, 1'b1);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(negedge clk_sys);
        check(15'({cmd_ready, ptr_b}), 15'h0000);
        check(pc, 15'h0000);
        check(15'(dmem_addr), 15'h0000);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check(15'(cmd_ready), 15'h0000);
        @(negedge clk_sys);
        check(15'(cmd_ready), 15'h0001);
        exp_pc = 15'h0002;
        run(mk(CAM_OP_DIRECT, 2'd2, 1'b0, 1'b0, CAM_POST_NONE, 15'h005c), 8'h00, 1, 1'b1);
        check(15'({saw_dm, dmem_addr}), 15'h015c);
        $display("test reset done");
    endtask : t_reset

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_operand();
        t_jumps();
        t_program();
        t_skip();
        t_reset();
        finish_test();
    end
endmodule : tb
`default_nettype wire
